// [include/door_power_regs_pkg.sv]
package door_power_regs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int NUM_REGS = 12;
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;

  localparam logic [ADDR_W-1:0] OFS_BRIDGE_A = 6'h0A;
  localparam logic [ADDR_W-1:0] OFS_HEATER_EC = 6'h0B;
  localparam logic [ADDR_W-1:0] OFS_PWM_FREQ = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_DUTY_ONE = 6'h0D;
  localparam logic [ADDR_W-1:0] OFS_DUTY_FOUR = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_LED_ONE = 6'h11;
  localparam logic [ADDR_W-1:0] OFS_LED_FOUR = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_BRIDGE_B = 6'h15;

  localparam logic [DATA_W-1:0] RST_BRIDGE = 24'hE0_0F00;
  localparam logic [DATA_W-1:0] RST_HEATER_EC = 24'h01_C000;
  localparam logic [DATA_W-1:0] RST_ZERO = 24'h00_0000;

  localparam logic [DATA_W-1:0] MASK_BRIDGE_A = 24'hFF_FFFF;
  localparam logic [DATA_W-1:0] MASK_HEATER_EC = 24'h03_F13F;
  localparam logic [DATA_W-1:0] MASK_PWM_FREQ = 24'hFF_FC00;
  localparam logic [DATA_W-1:0] MASK_DUTY = 24'h3F_F3FF;
  localparam logic [DATA_W-1:0] MASK_DUTY_LAST = 24'h3F_F000;
  localparam logic [DATA_W-1:0] MASK_LED = 24'h7F_F7FF;
  localparam logic [DATA_W-1:0] MASK_LED_LAST = 24'h7F_F000;
  localparam logic [DATA_W-1:0] MASK_BRIDGE_B = 24'hF0_0FFF;

  localparam int DS_LSB = 21;
  localparam int DIR_BIT = 20;
  localparam int BRIDGE_B_LEG2_SLOW_DECAY_BIT = 19;
  localparam int BRIDGE_B_LEG2_SINGLE_SLOW_DECAY_BIT = 18;
  localparam int SD1B_BIT = 17;
  localparam int SDS1B_BIT = 16;
  localparam int SD2A_BIT = 15;
  localparam int SDS2A_BIT = 14;
  localparam int BRIDGE_A_LEG1_SLOW_DECAY_BIT = 13;
  localparam int BRIDGE_A_LEG1_SINGLE_SLOW_DECAY_BIT = 12;
  localparam int DEAD_LSB = 8;
  localparam int OLH_BIT = 7;
  localparam int OL_DIAG1_BIT = 6;
  localparam int OL_DIAG2_BIT = 5;
  localparam int SLEW_LSB = 0;

  localparam int GH_OL_BIT = 17;
  localparam int GH_TH_LSB = 14;
  localparam int ELECTROCHROME_LOWSIDE_ON_BIT = 13;
  localparam int ELECTROCHROME_OVERCURRENT_RECOVERY_BIT = 12;
  localparam int ELECTROCHROME_CONTROL_ON_BIT = 8;
  localparam int EC_REF_LSB = 0;

  localparam int FREQ_TOP = 23;
  localparam int UPPER_LSB = 12;
  localparam int LOWER_LSB = 0;
  localparam int COMP_UPPER_BIT = 22;
  localparam int COMP_LOWER_BIT = 10;
  localparam int PWM_CHANNELS = 7;
  localparam int PAIR_REGS = 4;

  localparam logic [9:0] LED_CLAMP = 10'h1D0;
  localparam logic [3:0] OUT_CFG_ON = 4'h1;
endpackage

// [verilog/door_power_regs.sv]
`timescale 1ns/1ps
module door_power_regs (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  input wire logic vbat_wake,
  input wire logic electrochrome_high_range,
  input wire logic [3:0] mirror_supply_cfg,
  output logic [2:0] bridge_a_ds_threshold,
  output logic bridge_a_direction,
  output logic bridge_a_hs1_on,
  output logic bridge_a_hs2_on,
  output logic bridge_a_ls1_on,
  output logic bridge_a_ls2_on,
  output logic bridge_a_leg1_slow_decay,
  output logic bridge_a_leg1_single_slow_decay,
  output logic bridge_a_leg2_slow_decay,
  output logic bridge_a_leg2_single_slow_decay,
  output logic bridge_b_leg1_slow_decay,
  output logic bridge_b_leg1_single_slow_decay,
  output logic bridge_b_leg2_slow_decay,
  output logic bridge_b_leg2_single_slow_decay,
  output logic [3:0] bridge_a_dead_time,
  output logic bridge_a_openload_high_sel,
  output logic bridge_a_openload_test_diag1,
  output logic bridge_a_openload_test_diag2,
  output logic [4:0] bridge_a_slew,
  output logic [2:0] bridge_b_ds_threshold,
  output logic bridge_b_direction,
  output logic bridge_b_hs1_on,
  output logic bridge_b_hs2_on,
  output logic bridge_b_ls1_on,
  output logic bridge_b_ls2_on,
  output logic [3:0] bridge_b_dead_time,
  output logic bridge_b_openload_high_sel,
  output logic bridge_b_openload_test_diag1,
  output logic bridge_b_openload_test_diag2,
  output logic [4:0] bridge_b_slew,
  output logic heater_openload_enable,
  output logic [2:0] heater_ds_threshold,
  output logic electrochrome_lowside_on,
  output logic electrochrome_overcurrent_recovery,
  output logic electrochrome_control_on,
  output logic electrochrome_driver_pin,
  output logic mirror_supply_output,
  output logic [5:0] electrochrome_reference,
  output logic electrochrome_vmax_high,
  output logic [door_power_regs_pkg::PWM_CHANNELS-1:0][1:0] pwm_channel_freq_sel,
  output logic [door_power_regs_pkg::PAIR_REGS-1:0][9:0] pwm_upper_duty,
  output logic [door_power_regs_pkg::PAIR_REGS-2:0][9:0] pwm_lower_duty,
  output logic [door_power_regs_pkg::PWM_CHANNELS-1:0] led_supply_comp_enable,
  output logic [door_power_regs_pkg::PWM_CHANNELS-1:0][9:0] led_nominal_voltage
);
  import door_power_regs_pkg::*;

  logic [DATA_W-1:0] regs [NUM_REGS];
  logic sclk_s1, sclk_s2, sclk_s3;
  logic csn_s1, csn_s2, csn_s3;
  logic sdi_s1, sdi_s2;
  logic [5:0] bit_cnt;
  logic [FRAME_BITS-1:0] rx_shift;
  logic [DATA_W-1:0] tx_shift;
  logic sclk_rise, sclk_fall, frame_start, frame_end;
  logic [CMD_BITS-1:0] cmd_now;
  logic wr_commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a >= OFS_BRIDGE_A) && (a <= OFS_BRIDGE_B);
  endfunction

  function automatic int reg_index(input logic [ADDR_W-1:0] a);
    return int'(a - OFS_BRIDGE_A);
  endfunction

  function automatic logic [DATA_W-1:0] mask_of(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] m;
    m = RST_ZERO;
    if (a == OFS_BRIDGE_A) begin
      m = MASK_BRIDGE_A;
    end else if (a == OFS_HEATER_EC) begin
      m = MASK_HEATER_EC;
    end else if (a == OFS_PWM_FREQ) begin
      m = MASK_PWM_FREQ;
    end else if (a == OFS_DUTY_FOUR) begin
      m = MASK_DUTY_LAST;
    end else if (a >= OFS_DUTY_ONE && a < OFS_DUTY_FOUR) begin
      m = MASK_DUTY;
    end else if (a == OFS_LED_FOUR) begin
      m = MASK_LED_LAST;
    end else if (a >= OFS_LED_ONE && a < OFS_LED_FOUR) begin
      m = MASK_LED;
    end else if (a == OFS_BRIDGE_B) begin
      m = MASK_BRIDGE_B;
    end
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] reset_of(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = RST_ZERO;
    if (a == OFS_BRIDGE_A || a == OFS_BRIDGE_B) begin
      v = RST_BRIDGE;
    end else if (a == OFS_HEATER_EC) begin
      v = RST_HEATER_EC;
    end
    return v;
  endfunction

  function automatic logic [9:0] clamp_led(input logic [9:0] v);
    return (v > LED_CLAMP) ? LED_CLAMP : v;
  endfunction

  // masking keeps reserved bits zero, clamping keeps LED words in range
  function automatic logic [DATA_W-1:0] next_value(input logic [ADDR_W-1:0] a,
                                                   input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d & mask_of(a);
    if (a >= OFS_LED_ONE && a <= OFS_LED_FOUR) begin
      v[UPPER_LSB +: 10] = clamp_led(v[UPPER_LSB +: 10]);
      v[LOWER_LSB +: 10] = clamp_led(v[LOWER_LSB +: 10]);
    end
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a);
    return mapped(a) ? regs[reg_index(a)] : RST_ZERO;
  endfunction

  // pins cross into mclk through two flops before any edge logic
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      csn_s3 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csn_s1 <= spi_csn;
      csn_s2 <= csn_s1;
      csn_s3 <= csn_s2;
      sdi_s1 <= spi_sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3 & ~csn_s2;
  assign sclk_fall = ~sclk_s2 & sclk_s3 & ~csn_s2;
  assign frame_start = ~csn_s2 & csn_s3;
  assign frame_end = csn_s2 & ~csn_s3;
  assign cmd_now = {rx_shift[CMD_BITS-2:0], sdi_s2};

  // sclk must stay at or below mclk/8 so each sdo shift lands before the next sclk rise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 6'h00;
      rx_shift <= '0;
    end else if (frame_start) begin
      bit_cnt <= 6'h00;
      rx_shift <= '0;
    end else if (sclk_rise) begin
      rx_shift <= {rx_shift[FRAME_BITS-2:0], sdi_s2};
      if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // read data is the addressed word taken after the command byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_shift <= '0;
    end else if (frame_start) begin
      tx_shift <= '0;
    end else if (sclk_rise && bit_cnt == 6'(CMD_BITS - 1)) begin
      tx_shift <= (cmd_now[7:6] == OP_READ) ? read_value(cmd_now[5:0]) : RST_ZERO;
    end else if (sclk_fall && bit_cnt > 6'(CMD_BITS)) begin
      tx_shift <= {tx_shift[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      spi_sdo_oe_n <= 1'b1;
    end else begin
      spi_sdo_oe_n <= csn_s2;
    end
  end

  assign spi_sdo = tx_shift[DATA_W-1];

  // frames of any other length are dropped whole
  assign wr_addr = rx_shift[FRAME_BITS-3 -: ADDR_W];
  assign wr_data = rx_shift[DATA_W-1:0];
  assign wr_commit = frame_end && bit_cnt == 6'(FRAME_BITS) &&
                     rx_shift[FRAME_BITS-1 -: 2] == OP_WRITE && mapped(wr_addr);

  // wake-up clear is applied after the write so it wins the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= reset_of(ADDR_W'(i) + OFS_BRIDGE_A);
      end
    end else begin
      if (wr_commit) begin
        regs[reg_index(wr_addr)] <= next_value(wr_addr, wr_data);
      end
      if (vbat_wake) begin
        regs[reg_index(OFS_HEATER_EC)][EC_REF_LSB +: 6] <= 6'h00;
      end
    end
  end

  // derived switch commands, registered so pins never glitch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mirror_supply_output <= 1'b0;
      electrochrome_vmax_high <= 1'b0;
    end else begin
      mirror_supply_output <= electrochrome_control_on ||
                              mirror_supply_cfg == OUT_CFG_ON;
      electrochrome_vmax_high <= electrochrome_high_range;
    end
  end

  assign bridge_a_ds_threshold = regs[0][DS_LSB +: 3];
  assign bridge_a_direction = regs[0][DIR_BIT];
  assign bridge_a_hs1_on = regs[0][DIR_BIT];
  assign bridge_a_ls2_on = regs[0][DIR_BIT];
  assign bridge_a_hs2_on = ~regs[0][DIR_BIT];
  assign bridge_a_ls1_on = ~regs[0][DIR_BIT];
  assign bridge_b_leg2_slow_decay = regs[0][BRIDGE_B_LEG2_SLOW_DECAY_BIT];
  assign bridge_b_leg2_single_slow_decay = regs[0][BRIDGE_B_LEG2_SINGLE_SLOW_DECAY_BIT];
  assign bridge_b_leg1_slow_decay = regs[0][SD1B_BIT];
  assign bridge_b_leg1_single_slow_decay = regs[0][SDS1B_BIT];
  assign bridge_a_leg2_slow_decay = regs[0][SD2A_BIT];
  assign bridge_a_leg2_single_slow_decay = regs[0][SDS2A_BIT];
  assign bridge_a_leg1_slow_decay = regs[0][BRIDGE_A_LEG1_SLOW_DECAY_BIT];
  assign bridge_a_leg1_single_slow_decay = regs[0][BRIDGE_A_LEG1_SINGLE_SLOW_DECAY_BIT];
  assign bridge_a_dead_time = regs[0][DEAD_LSB +: 4];
  assign bridge_a_openload_high_sel = regs[0][OLH_BIT];
  assign bridge_a_openload_test_diag1 = regs[0][OL_DIAG1_BIT];
  assign bridge_a_openload_test_diag2 = regs[0][OL_DIAG2_BIT];
  assign bridge_a_slew = regs[0][SLEW_LSB +: 5];

  assign heater_openload_enable = regs[1][GH_OL_BIT];
  assign heater_ds_threshold = regs[1][GH_TH_LSB +: 3];
  assign electrochrome_lowside_on = regs[1][ELECTROCHROME_LOWSIDE_ON_BIT];
  assign electrochrome_overcurrent_recovery = regs[1][ELECTROCHROME_OVERCURRENT_RECOVERY_BIT];
  assign electrochrome_control_on = regs[1][ELECTROCHROME_CONTROL_ON_BIT];
  assign electrochrome_driver_pin = regs[1][ELECTROCHROME_CONTROL_ON_BIT];
  assign electrochrome_reference = regs[1][EC_REF_LSB +: 6];

  // channel 1 sits in the top pair, channel 7 at bits 11:10
  always_comb begin
    for (int c = 0; c < PWM_CHANNELS; c++) begin
      pwm_channel_freq_sel[c] = regs[2][FREQ_TOP - 2*c -: 2];
    end
  end

  // pair k carries odd channel 2k+1 high and, except in the last pair, even channel 2k+2 low
  always_comb begin
    for (int k = 0; k < PAIR_REGS; k++) begin
      pwm_upper_duty[k] = regs[3 + k][UPPER_LSB +: 10];
    end
    for (int k = 0; k < PAIR_REGS - 1; k++) begin
      pwm_lower_duty[k] = regs[3 + k][LOWER_LSB +: 10];
    end
  end

  // output order 7,8,9,10,13,14,15; the last pair has no low half
  always_comb begin
    for (int k = 0; k < PAIR_REGS; k++) begin
      led_nominal_voltage[2*k] = regs[7 + k][UPPER_LSB +: 10];
      led_supply_comp_enable[2*k] = regs[7 + k][COMP_UPPER_BIT];
    end
    for (int k = 0; k < PAIR_REGS - 1; k++) begin
      led_nominal_voltage[2*k + 1] = regs[7 + k][LOWER_LSB +: 10];
      led_supply_comp_enable[2*k + 1] = regs[7 + k][COMP_LOWER_BIT];
    end
  end

  assign bridge_b_ds_threshold = regs[11][DS_LSB +: 3];
  assign bridge_b_direction = regs[11][DIR_BIT];
  assign bridge_b_hs1_on = regs[11][DIR_BIT];
  assign bridge_b_ls2_on = regs[11][DIR_BIT];
  assign bridge_b_hs2_on = ~regs[11][DIR_BIT];
  assign bridge_b_ls1_on = ~regs[11][DIR_BIT];
  assign bridge_b_dead_time = regs[11][DEAD_LSB +: 4];
  assign bridge_b_openload_high_sel = regs[11][OLH_BIT];
  assign bridge_b_openload_test_diag1 = regs[11][OL_DIAG1_BIT];
  assign bridge_b_openload_test_diag2 = regs[11][OL_DIAG2_BIT];
  assign bridge_b_slew = regs[11][SLEW_LSB +: 5];

  logic led_over;
  logic reserved_set;
  always_comb begin
    led_over = 1'b0;
    reserved_set = 1'b0;
    for (int k = 0; k < PWM_CHANNELS; k++) begin
      led_over = led_over | (led_nominal_voltage[k] > LED_CLAMP);
    end
    for (int i = 0; i < NUM_REGS; i++) begin
      reserved_set = reserved_set |
                     (|(regs[i] & ~mask_of(ADDR_W'(i) + OFS_BRIDGE_A)));
    end
  end

  a_reset_thresholds: assert property (@(posedge mclk) $rose(nrst) |->
    bridge_a_ds_threshold == 3'h7 && bridge_b_ds_threshold == 3'h7 &&
    heater_ds_threshold == 3'h7 && bridge_a_dead_time == 4'hF)
    else $error("threshold or dead time reset value wrong");

  a_dir_pairs: assert property (@(posedge mclk) disable iff (!nrst)
    bridge_a_hs1_on == bridge_a_direction && bridge_a_ls2_on == bridge_a_direction &&
    bridge_a_hs2_on != bridge_a_direction && bridge_a_ls1_on != bridge_a_direction)
    else $error("bridge direction pair wrong");

  a_write_bridge_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr_commit && wr_addr == OFS_BRIDGE_A |=>
    bridge_a_leg1_slow_decay == $past(wr_data[BRIDGE_A_LEG1_SLOW_DECAY_BIT]) &&
    bridge_a_slew == $past(wr_data[SLEW_LSB +: 5]))
    else $error("bridge A write not applied");

  a_write_bridge_b: assert property (@(posedge mclk) disable iff (!nrst)
    wr_commit && wr_addr == OFS_BRIDGE_B |=>
    bridge_b_direction == $past(wr_data[DIR_BIT]) &&
    bridge_b_dead_time == $past(wr_data[DEAD_LSB +: 4]))
    else $error("bridge B write not applied");

  a_wake_clears_ref: assert property (@(posedge mclk) disable iff (!nrst)
    vbat_wake |=> electrochrome_reference == 6'h00)
    else $error("reference not cleared on wake-up");

  a_electrochrome_control_on_forces: assert property (@(posedge mclk) disable iff (!nrst)
    electrochrome_control_on |-> electrochrome_driver_pin ##1 mirror_supply_output)
    else $error("electro-chrome control did not force outputs");

  a_led_clamped: assert property (@(posedge mclk) disable iff (!nrst)
    !led_over)
    else $error("LED voltage above clamp");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
    !reserved_set)
    else $error("reserved bit set");

  a_vmax_follow: assert property (@(posedge mclk) disable iff (!nrst)
    electrochrome_high_range [*2] |-> electrochrome_vmax_high)
    else $error("high range not followed");

  a_sdo_idle: assert property (@(posedge mclk) disable iff (!nrst)
    csn_s2 [*2] |-> spi_sdo_oe_n)
    else $error("data out driven while deselected");

  c_write: cover property (@(posedge mclk) disable iff (!nrst) wr_commit);
  c_read_frame: cover property (@(posedge mclk) disable iff (!nrst)
    sclk_rise && bit_cnt == 6'(CMD_BITS - 1) && cmd_now[7:6] == OP_READ);
  c_wake: cover property (@(posedge mclk) disable iff (!nrst)
    vbat_wake && electrochrome_reference != 6'h00);
  c_clamp: cover property (@(posedge mclk) disable iff (!nrst)
    wr_commit && wr_addr == OFS_LED_ONE && wr_data[UPPER_LSB +: 10] > LED_CLAMP);
endmodule

// [testbench/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  // sclk phase length in mclk cycles; 4 is the fastest the device takes
  int half = 5;
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b1;
  end
  // mode 0, msb first; sclk stands low and sdi shows the inverse of its last bit between frames
  task automatic xfer(input logic [1:0] op, input logic [5:0] addr, input logic [23:0] wd,
                      input int nbits, output logic [23:0] rd);
    logic [31:0] f;
    f = {op, addr, wd};
    rd = '0;
    @(posedge mclk) spi_csn <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 31; i > 31 - nbits; i--) begin
      spi_sdi <= f[i];
      repeat (half) @(posedge mclk);
      spi_sclk <= 1'b1;
      // data phase bit sampled as sclk rises; undriven line reads unknown
      if (i < 24) rd[i] = spi_sdo_oe_n ? 1'bx : spi_sdo;
      repeat (half) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (half) @(posedge mclk);
    spi_csn <= 1'b1;
    spi_sdi <= ~spi_sdi;
    // gap covers csn sync plus register and derived output latency
    repeat (10) @(posedge mclk);
  endtask
endmodule

// [testbench/bridge_pwm_led_ctrl_regs_tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); \
  end \
end
module bridge_pwm_led_ctrl_regs_tb_top;
  import door_power_regs_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic vbat_wake = 1'b0;
  logic electrochrome_high_range = 1'b0;
  logic [3:0] mirror_supply_cfg = 4'h0;
  logic spi_sclk, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe_n;
  logic [2:0] bridge_a_ds_threshold, bridge_b_ds_threshold, heater_ds_threshold;
  logic bridge_a_direction, bridge_a_hs1_on, bridge_a_hs2_on, bridge_a_ls1_on, bridge_a_ls2_on;
  logic bridge_b_direction, bridge_b_hs1_on, bridge_b_hs2_on, bridge_b_ls1_on, bridge_b_ls2_on;
  logic bridge_a_leg1_slow_decay, bridge_a_leg1_single_slow_decay;
  logic bridge_a_leg2_slow_decay, bridge_a_leg2_single_slow_decay;
  logic bridge_b_leg1_slow_decay, bridge_b_leg1_single_slow_decay;
  logic bridge_b_leg2_slow_decay, bridge_b_leg2_single_slow_decay;
  logic [3:0] bridge_a_dead_time, bridge_b_dead_time;
  logic [4:0] bridge_a_slew, bridge_b_slew;
  logic bridge_a_openload_high_sel, bridge_a_openload_test_diag1, bridge_a_openload_test_diag2;
  logic bridge_b_openload_high_sel, bridge_b_openload_test_diag1, bridge_b_openload_test_diag2;
  logic heater_openload_enable, electrochrome_lowside_on, electrochrome_overcurrent_recovery;
  logic electrochrome_control_on, electrochrome_driver_pin, mirror_supply_output;
  logic electrochrome_vmax_high;
  logic [5:0] electrochrome_reference;
  logic [PWM_CHANNELS-1:0][1:0] pwm_channel_freq_sel;
  logic [PAIR_REGS-1:0][9:0] pwm_upper_duty;
  logic [PAIR_REGS-2:0][9:0] pwm_lower_duty;
  logic [PWM_CHANNELS-1:0] led_supply_comp_enable;
  logic [PWM_CHANNELS-1:0][9:0] led_nominal_voltage;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  wire [7:0] sd_bits = {bridge_b_leg2_slow_decay, bridge_b_leg2_single_slow_decay,
    bridge_b_leg1_slow_decay, bridge_b_leg1_single_slow_decay, bridge_a_leg2_slow_decay,
    bridge_a_leg2_single_slow_decay, bridge_a_leg1_slow_decay, bridge_a_leg1_single_slow_decay};
  wire [3:0] sw_a = {bridge_a_hs1_on, bridge_a_hs2_on, bridge_a_ls1_on, bridge_a_ls2_on};
  wire [3:0] sw_b = {bridge_b_hs1_on, bridge_b_hs2_on, bridge_b_ls1_on, bridge_b_ls2_on};

  door_power_regs i_dut (.*);
  spi_host_model i_host (.*);

  always #2 mclk = ~mclk;

  task automatic give_verdict();
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ceiling well above the roughly 36k cycles the scenarios need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic wr(input logic [5:0] a, input logic [23:0] d, input int n = 32,
                    input logic [1:0] op = OP_WRITE);
    logic [23:0] r;
    i_host.xfer(op, a, d, n, r);
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] r;
    i_host.xfer(OP_READ, a, 24'h00_0000, 32, r);
    `CHK(r, e)
  endtask

  task automatic t_reset();
    logic [23:0] e;
    `CHK({bridge_a_ds_threshold, bridge_b_ds_threshold}, 6'h3F)
    `CHK({sw_a, sw_b}, 8'h66)
    `CHK({sd_bits, bridge_a_dead_time, bridge_a_slew}, 17'h0_01E0)
    `CHK({heater_openload_enable, heater_ds_threshold}, 4'h7)
    `CHK({electrochrome_lowside_on, electrochrome_overcurrent_recovery}, 2'b00)
    `CHK({electrochrome_control_on, electrochrome_driver_pin}, 2'b00)
    `CHK({pwm_channel_freq_sel, pwm_upper_duty, pwm_lower_duty}, 84'h0)
    `CHK({led_supply_comp_enable, led_nominal_voltage}, 77'h0)
    i_host.half = 4;
    for (int a = 10; a <= 21; a++) begin
      e = (a == 10 || a == 21) ? RST_BRIDGE : (a == 11) ? RST_HEATER_EC : RST_ZERO;
      rd(6'(a), e);
    end
    i_host.half = 9;
  endtask

  task automatic t_bridge();
    logic [3:0] c;
    wr(OFS_BRIDGE_A, {3'b001, 1'b1, 8'hA5, 4'h0, 3'b110, 5'h1F});
    `CHK({bridge_a_ds_threshold, bridge_a_direction, sw_a}, 8'h39)
    `CHK(sd_bits, 8'hA5)
    `CHK({bridge_a_openload_high_sel, bridge_a_openload_test_diag1}, 2'b11)
    `CHK({bridge_a_openload_test_diag2, bridge_a_slew}, 6'h1F)
    rd(OFS_BRIDGE_A, {3'b001, 1'b1, 8'hA5, 4'h0, 3'b110, 5'h1F});
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(OFS_BRIDGE_A, {c[2:0], 1'b0, 8'h5A, c, 3'b001, c, 1'b1});
      `CHK({bridge_a_ds_threshold, sw_a, sd_bits}, {c[2:0], 4'h6, 8'h5A})
      `CHK({bridge_a_dead_time, bridge_a_slew}, {c, c, 1'b1})
      `CHK({bridge_a_openload_test_diag1, bridge_a_openload_test_diag2}, 2'b01)
    end
    wr(OFS_BRIDGE_B, 24'hFF_FFFF);
    rd(OFS_BRIDGE_B, 24'hF0_0FFF);
    `CHK({bridge_b_ds_threshold, bridge_b_direction, sw_b, bridge_b_dead_time}, 12'hF9F)
    `CHK({bridge_b_openload_high_sel, bridge_b_openload_test_diag1}, 2'b11)
    `CHK({bridge_b_openload_test_diag2, bridge_b_slew, sd_bits}, 14'h3F5A)
    wr(OFS_BRIDGE_B, 24'h10_0000);
    `CHK({bridge_b_ds_threshold, bridge_b_direction, sw_b}, 8'h19)
  endtask

  task automatic t_heater();
    wr(OFS_HEATER_EC, 24'hFF_FFFF);
    rd(OFS_HEATER_EC, 24'h03_F13F);
    `CHK({heater_openload_enable, heater_ds_threshold}, 4'hF)
    `CHK({electrochrome_lowside_on, electrochrome_overcurrent_recovery}, 2'b11)
    `CHK({electrochrome_control_on, electrochrome_driver_pin, mirror_supply_output}, 3'h7)
    `CHK(electrochrome_reference, 6'h3F)
    @(posedge mclk) vbat_wake <= 1'b1;
    @(posedge mclk) vbat_wake <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK({electrochrome_reference, electrochrome_lowside_on}, 7'h01)
    wr(OFS_HEATER_EC, 24'h00_002A);
    `CHK(electrochrome_reference, 6'h2A)
    `CHK({electrochrome_control_on, electrochrome_driver_pin, mirror_supply_output}, 3'h0)
    @(posedge mclk) mirror_supply_cfg <= OUT_CFG_ON;
    electrochrome_high_range <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK({mirror_supply_output, electrochrome_vmax_high}, 2'b11)
    @(posedge mclk) mirror_supply_cfg <= 4'h2;
    electrochrome_high_range <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK({mirror_supply_output, electrochrome_vmax_high}, 2'b00)
  endtask

  task automatic t_pwm_led();
    logic [23:0] e;
    wr(OFS_PWM_FREQ, 24'h1B_1800);
    for (int c = 0; c < 7; c++) `CHK(pwm_channel_freq_sel[c], 2'(c % 4))
    wr(OFS_PWM_FREQ, 24'hFF_FFFF);
    rd(OFS_PWM_FREQ, 24'hFF_FC00);
    for (int k = 0; k < 4; k++) begin
      wr(6'(OFS_DUTY_ONE + k), {2'b11, 10'h3FF - 10'(k), 2'b11, 10'h200 + 10'(k)});
      `CHK(pwm_upper_duty[k], 10'h3FF - 10'(k))
      if (k < 3) `CHK(pwm_lower_duty[k], 10'h200 + 10'(k))
      e = (k < 3) ? 24'h3F_F200 + 24'(k) - 24'(k << 12) : 24'h3F_C000;
      rd(6'(OFS_DUTY_ONE + k), e);
      wr(6'(OFS_LED_ONE + k), 24'hFF_FFFF);
      rd(6'(OFS_LED_ONE + k), (k < 3) ? 24'h5D_05D0 : 24'h5D_0000);
      `CHK({led_supply_comp_enable[2*k], led_nominal_voltage[2*k]}, 11'h5D0)
      wr(6'(OFS_LED_ONE + k), {2'b00, 10'h1CF, 2'b01, 10'h1D1});
      `CHK({led_supply_comp_enable[2*k], led_nominal_voltage[2*k]}, 11'h1CF)
      if (k < 3) `CHK({led_supply_comp_enable[2*k+1], led_nominal_voltage[2*k+1]}, 11'h5D0)
    end
  endtask

  task automatic t_refuse();
    wr(OFS_PWM_FREQ, 24'h00_0000, 31);
    wr(OFS_PWM_FREQ, 24'h00_0000, 32, 2'h2);
    wr(OFS_PWM_FREQ, 24'h00_0000, 32, 2'h3);
    `CHK(pwm_channel_freq_sel, 14'h3FFF)
    rd(OFS_PWM_FREQ, 24'hFF_FC00);
    wr(6'h09, 24'hFF_FFFF);
    rd(6'h09, 24'h00_0000);
    rd(6'h3F, 24'h00_0000);
    `CHK(spi_sdo_oe_n, 1'b1)
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_bridge();
    t_heater();
    t_pwm_led();
    t_refuse();
    give_verdict();
  end
endmodule
